/* File: rtl/touch_key_scan_counters.sv */
module touch_key_scan_counters
  import touch_pkg::*;
#(
  parameter int NUM_MODULES = 5
)
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire touch_pkg::apb_req_t       apb_req,
  output logic                           pready,
  output logic [touch_pkg::DATA_W-1:0]   prdata,
  output logic                           pslverr,
  input  wire logic [NUM_MODULES*4-1:0]  key_osc_in,
  output logic [NUM_MODULES*4-1:0]       key_pin_touch_sel,
  output logic [NUM_MODULES-1:0]         key_osc_en,
  output logic [NUM_MODULES-1:0]         ref_osc_en,
  output logic [NUM_MODULES*10-1:0]      ref_osc_cap,
  output logic [1:0]                     osc_freq_sel,
  output logic                           irq
);

  // ----------------------------------------------------------------
  // module register set
  // ----------------------------------------------------------------
  localparam int NK = NUM_MODULES * KEYS_PER_MOD;

  logic [7:0]       slot_counter_preload_reg;
  logic [7:0]       touch_control_main_reg;
  logic [15:0]      func_cnt_reg;
  logic [FDIV_W-1:0] fdiv_reg;
  logic [OSC_FREQ_W-1:0] oscillator_freq_control_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [REF_W-1:0] ref_cap_reg   [NUM_MODULES];
  logic [7:0]       ctl_a_reg     [NUM_MODULES];
  logic [7:0]       ctl_b_reg     [NUM_MODULES];
  logic [15:0]      mod_cnt       [NUM_MODULES];
  logic [NUM_MODULES-1:0] mod_ovf;
  logic [NUM_MODULES-1:0] slot_ovf;
  logic [NUM_MODULES-1:0] slot_run;
  logic [NUM_MODULES-1:0] slot_done_reg;
  logic [NUM_MODULES-1:0] mod_en;
  detect_state_t    state_reg;
  logic             start_prev_reg;
  logic             start_bit;
  logic             start_edge;
  logic             start_clear;
  logic             share;
  logic             global_ovf;
  logic             running;
  logic             fcnt_tick;
  logic             fcnt_ovf;
  logic [FDIV_W-1:0] fdiv_mask;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic                 wr_en;
  logic                 rd_setup;
  logic                 in_mod;
  logic [ADDR_W-1:0]    mod_rel;
  logic [2:0]           mod_idx;
  logic [4:0]           mod_ofs;
  logic                 mapped;
  logic [7:0]           wbyte;
  logic [DATA_W-1:0]    rd_value;

  // read data only ever uses the low byte; upper bits read as zero
  function automatic logic [DATA_W-1:0] zext8(input logic [7:0] v);
    return {{(DATA_W-8){1'b0}}, v};
  endfunction

  // hardware set beats a software clear in the same cycle
  function automatic logic sticky(input logic cur, input logic wr,
                                  input logic wval, input logic set);
    return set | (wr ? wval : cur);
  endfunction

  assign wbyte    = apb_req.pwdata[7:0];
  assign mod_rel  = apb_req.paddr - OFS_MOD_BASE;
  assign in_mod   = apb_req.paddr >= OFS_MOD_BASE &&
                    mod_rel < ADDR_W'(NUM_MODULES) * OFS_MOD_SPAN;
  assign mod_idx  = mod_rel[7:5];
  assign mod_ofs  = mod_rel[4:0];

  always_comb
  begin
    mapped = 1'b1;
    case (apb_req.paddr)
      OFS_PRELOAD, OFS_CTL_MAIN, OFS_FUNC_LO, OFS_FUNC_HI,
      OFS_OSC_FREQ, OFS_IRQ_STAT, OFS_IRQ_MASK: mapped = 1'b1;
      default:
        mapped = in_mod && mod_ofs <= MOFS_CTL_B && mod_ofs[1:0] == 2'b00;
    endcase
  end

  assign pready   = 1'b1;
  assign pslverr  = apb_req.psel && apb_req.penable && !mapped;
  assign wr_en    = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                    mapped;
  assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

  function automatic logic mod_wr(input logic [2:0] idx,
                                  input logic [4:0] ofs);
    return wr_en && !mapped_fixed(apb_req.paddr) && in_mod &&
           mod_idx == idx && mod_ofs == ofs;
  endfunction

  function automatic logic mapped_fixed(input logic [ADDR_W-1:0] a);
    return a < OFS_MOD_BASE;
  endfunction

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_value = '0;
    case (apb_req.paddr)
      OFS_PRELOAD:  rd_value = zext8(slot_counter_preload_reg);
      OFS_CTL_MAIN: rd_value = zext8(touch_control_main_reg);
      OFS_FUNC_LO:  rd_value = zext8(func_cnt_reg[7:0]);
      OFS_FUNC_HI:  rd_value = zext8(func_cnt_reg[15:8]);
      OFS_OSC_FREQ: rd_value = zext8(8'(oscillator_freq_control_reg));
      OFS_IRQ_STAT: rd_value = zext8(8'(irq_stat_reg));
      OFS_IRQ_MASK: rd_value = zext8(8'(irq_mask_reg));
      default:
        if (in_mod)
          case (mod_ofs)
            MOFS_CNT_LO: rd_value = zext8(mod_cnt[mod_idx][7:0]);
            MOFS_CNT_HI: rd_value = zext8(mod_cnt[mod_idx][15:8]);
            MOFS_REF_LO: rd_value = zext8(ref_cap_reg[mod_idx][7:0]);
            MOFS_REF_HI:
              rd_value = zext8(8'(ref_cap_reg[mod_idx][REF_W-1:8]));
            MOFS_CTL_A:  rd_value = zext8(ctl_a_reg[mod_idx]);
            MOFS_CTL_B:  rd_value = zext8(ctl_b_reg[mod_idx]);
            default:     rd_value = '0;
          endcase
    endcase
  end

  // sampled in the setup cycle so prdata is a flop during the access
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= '0;
    else if (rd_setup)
      prdata <= rd_value;

  // ----------------------------------------------------------------
  // main control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      slot_counter_preload_reg <= RST_PRELOAD;
    else if (wr_en && apb_req.paddr == OFS_PRELOAD)
      slot_counter_preload_reg <= wbyte;

  logic ctl_wr;
  logic any_mod_ovf;
  assign ctl_wr      = wr_en && apb_req.paddr == OFS_CTL_MAIN;
  assign any_mod_ovf = |(mod_ovf & mod_en);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      touch_control_main_reg <= RST_CTL_MAIN;
    else
    begin
      if (ctl_wr)
        touch_control_main_reg <= wbyte & CTL_WMASK;
      touch_control_main_reg[CTL_SLOT_OVF] <= sticky(
        touch_control_main_reg[CTL_SLOT_OVF], ctl_wr,
        wbyte[CTL_SLOT_OVF], global_ovf);
      touch_control_main_reg[CTL_MCNT_OVF] <= sticky(
        touch_control_main_reg[CTL_MCNT_OVF], ctl_wr,
        wbyte[CTL_MCNT_OVF], any_mod_ovf);
      touch_control_main_reg[CTL_FCNT_OVF] <= sticky(
        touch_control_main_reg[CTL_FCNT_OVF], ctl_wr,
        wbyte[CTL_FCNT_OVF], fcnt_ovf);
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      oscillator_freq_control_reg <= RST_OSC_FREQ;
    else if (wr_en && apb_req.paddr == OFS_OSC_FREQ)
      oscillator_freq_control_reg <= wbyte[OSC_FREQ_W-1:0];

  assign osc_freq_sel = oscillator_freq_control_reg;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  logic             stat_wr;
  assign irq_set = {any_mod_ovf, fcnt_ovf, global_ovf};
  assign stat_wr = wr_en && apb_req.paddr == OFS_IRQ_STAT;

  // write one to clear; a new event in the same cycle stays set
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_stat_reg <= '0;
    else
      irq_stat_reg <= irq_set |
        (irq_stat_reg & ~(stat_wr ? wbyte[IRQ_W-1:0] : '0));

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_mask_reg <= '0;
    else if (wr_en && apb_req.paddr == OFS_IRQ_MASK)
      irq_mask_reg <= wbyte[IRQ_W-1:0];

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // detection sequencing
  // ----------------------------------------------------------------
  assign start_bit   = touch_control_main_reg[CTL_START];
  assign start_edge  = start_bit && !start_prev_reg;
  assign start_clear = !start_bit;
  assign share       = touch_control_main_reg[CTL_SHARE];
  // shared mode waits on module 0; own mode on every module
  assign global_ovf  = running && (share ? slot_ovf[0] :
                       &(slot_done_reg | slot_ovf));
  assign running     = state_reg == ST_RUN;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      start_prev_reg <= 1'b0;
    else
      start_prev_reg <= start_bit;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      state_reg <= ST_IDLE;
    else
      case (state_reg)
        ST_IDLE: if (start_edge) state_reg <= ST_RUN;
        ST_RUN:
          if (start_clear)
            state_reg <= ST_IDLE;
          else if (global_ovf)
            state_reg <= ST_DONE;
        ST_DONE: if (start_clear) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      slot_done_reg <= '0;
    else if (start_edge || start_clear)
      slot_done_reg <= '0;
    else
      slot_done_reg <= slot_done_reg | slot_ovf;

  // ----------------------------------------------------------------
  // function counter
  // ----------------------------------------------------------------
  always_comb
  begin
    case (touch_control_main_reg[CTL_CLKSEL_HI:0])
      2'b00:   fdiv_mask = 3'h0;
      2'b01:   fdiv_mask = 3'h1;
      2'b10:   fdiv_mask = 3'h3;
      default: fdiv_mask = 3'h7;
    endcase
  end

  assign fcnt_tick = running && (fdiv_reg & fdiv_mask) == fdiv_mask;
  assign fcnt_ovf  = fcnt_tick && func_cnt_reg == CNT_LAST;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      fdiv_reg <= '0;
    else if (start_clear)
      fdiv_reg <= '0;
    else if (running)
      fdiv_reg <= fdiv_reg + 1'b1;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      func_cnt_reg <= '0;
    else if (start_clear)
      func_cnt_reg <= '0;
    else if (fcnt_tick)
      func_cnt_reg <= func_cnt_reg + 1'b1;

  // ----------------------------------------------------------------
  // per-module slices
  // ----------------------------------------------------------------
  for (genvar m = 0; m < NUM_MODULES; m++)
  begin : g_mod
    always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
        ref_cap_reg[m] <= '0;
        ctl_a_reg[m]   <= '0;
        ctl_b_reg[m]   <= '0;
      end
      else
      begin
        if (mod_wr(3'(m), MOFS_REF_LO))
          ref_cap_reg[m][7:0] <= wbyte;
        if (mod_wr(3'(m), MOFS_REF_HI))
          ref_cap_reg[m][REF_W-1:8] <= wbyte[REF_W-9:0];
        if (mod_wr(3'(m), MOFS_CTL_A))
          ctl_a_reg[m] <= wbyte;
        if (mod_wr(3'(m), MOFS_CTL_B))
          ctl_b_reg[m] <= wbyte;
      end

    // in own mode a module stops as soon as its own slot ends
    assign mod_en[m] = running && (share || !slot_done_reg[m]);

    slot_timer u_slot (
      .pclk       (pclk),
      .presetn    (presetn),
      .start_edge (start_edge),
      .clear      (start_clear),
      .stop       (global_ovf),
      .preload    (slot_counter_preload_reg),
      .ovf        (slot_ovf[m]),
      .running    (slot_run[m])
    );

    freq_counter u_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (start_clear),
      .enable  (mod_en[m]),
      .key_osc (key_osc_in[m*KEYS_PER_MOD +: KEYS_PER_MOD]),
      .key_sel (ctl_a_reg[m][CTLA_MUX_LO +: 2]),
      .count   (mod_cnt[m]),
      .ovf     (mod_ovf[m])
    );

    assign key_osc_en[m] = mod_en[m] && slot_run[m];
    assign ref_osc_en[m] = mod_en[m] && slot_run[m];
    assign ref_osc_cap[m*REF_W +: REF_W] = ref_cap_reg[m];
    assign key_pin_touch_sel[m*KEYS_PER_MOD +: KEYS_PER_MOD] =
      ctl_b_reg[m][CTLB_IO_W-1:0];
  end

endmodule

/* File: rtl/touch_pkg.sv */
// Overview of operation
// - keys form modules of four keys; each key has its own oscillator
// - each module owns its own control logic and register set
// - module count is a parameter from one to five
// - touch function of each shared pin chosen by its own select bit
// - 5-bit prescaler gives one unit period per 32 slot clocks
// - 8-bit slot counter loads preload, overflows after 256-preload units
// - selected slot overflow sets slot overflow flag bit 6 and irq flag
// - slot overflow stops all key and reference oscillators
// - slot overflow stops frequency, function, unit and slot counters
// - start bit low clears frequency, function and unit counters
// - start bit low leaves 8-bit slot counter unchanged
// - start bit rising enables all counters and oscillators together
// - start control is bit 5 of main control register
// - module counter overflow flag bit 4 set by hardware, cleared by 0
// - function counter overflow flag bit 3 set by hardware, cleared by 0
// - share select bit 2: own slot counters or module 0 counter
// - bits 1..0 pick function clock divide by 1, 2, 4 or 8
package touch_pkg;

  // ----------------------------------------------------------------
  // bus and map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  localparam logic [ADDR_W-1:0] OFS_PRELOAD   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CTL_MAIN  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_FUNC_LO   = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_FUNC_HI   = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_OSC_FREQ  = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_MOD_BASE  = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_MOD_SPAN  = 12'h020;
  // offsets inside one module window
  localparam logic [4:0] MOFS_CNT_LO = 5'h00;
  localparam logic [4:0] MOFS_CNT_HI = 5'h04;
  localparam logic [4:0] MOFS_REF_LO = 5'h08;
  localparam logic [4:0] MOFS_REF_HI = 5'h0C;
  localparam logic [4:0] MOFS_CTL_A  = 5'h10;
  localparam logic [4:0] MOFS_CTL_B  = 5'h14;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int CTL_SLOT_OVF  = 6;
  localparam int CTL_START     = 5;
  localparam int CTL_MCNT_OVF  = 4;
  localparam int CTL_FCNT_OVF  = 3;
  localparam int CTL_SHARE     = 2;
  localparam int CTL_CLKSEL_HI = 1;
  localparam logic [7:0] CTL_WMASK = 8'h7F;
  localparam int CTLA_MUX_LO   = 6;
  localparam int CTLB_IO_W     = 4;
  localparam int REF_W         = 10;
  localparam int OSC_FREQ_W    = 2;

  localparam int IRQ_TOUCH = 0;
  localparam int IRQ_FCNT  = 1;
  localparam int IRQ_MCNT  = 2;
  localparam int IRQ_W     = 3;

  localparam logic [7:0] RST_PRELOAD  = 8'h00;
  localparam logic [7:0] RST_CTL_MAIN = 8'h00;
  localparam logic [OSC_FREQ_W-1:0] RST_OSC_FREQ = 2'h3;

  // ----------------------------------------------------------------
  // counters and states
  // ----------------------------------------------------------------
  localparam int KEYS_PER_MOD = 4;
  localparam int PRESC_W      = 5;
  localparam logic [PRESC_W-1:0] PRESC_LAST = 5'h1F;
  localparam logic [7:0] SLOT_LAST = 8'hFF;
  localparam logic [15:0] CNT_LAST = 16'hFFFF;
  localparam int FDIV_W = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } detect_state_t;

endpackage

/* File: rtl/slot_timer.sv */
module slot_timer
  import touch_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start_edge,
  input  wire logic       clear,
  input  wire logic       stop,
  input  wire logic [7:0] preload,
  output logic            ovf,
  output logic            running
);
  logic [PRESC_W-1:0] presc_reg;
  logic [7:0]         slot_reg;
  logic               unit_tick;

  assign unit_tick = running && presc_reg == PRESC_LAST;
  assign ovf       = unit_tick && slot_reg == SLOT_LAST;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      presc_reg <= '0;
    else if (clear)
      presc_reg <= '0;
    else if (running)
      presc_reg <= presc_reg + 1'b1;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      slot_reg <= '0;
    else if (start_edge)
      slot_reg <= preload;
    else if (unit_tick)
      slot_reg <= slot_reg + 1'b1;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      running <= 1'b0;
    else if (start_edge)
      running <= 1'b1;
    else if (clear || stop || ovf)
      running <= 1'b0;
endmodule

/* File: rtl/freq_counter.sv */
module freq_counter
  import touch_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clear,
  input  wire logic                    enable,
  input  wire logic [KEYS_PER_MOD-1:0] key_osc,
  input  wire logic [1:0]              key_sel,
  output logic [15:0]                  count,
  output logic                         ovf
);
  logic prev_reg;
  logic rise;

  assign rise = key_osc[key_sel] && !prev_reg;
  assign ovf  = enable && rise && count == CNT_LAST;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prev_reg <= 1'b0;
    else
      prev_reg <= key_osc[key_sel];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      count <= '0;
    else if (clear)
      count <= '0;
    else if (enable && rise)
      count <= count + 1'b1;
endmodule

/* File: tb/touch_pads.sv */
module touch_pads
  import touch_pkg::*;
#(
  parameter int NUM_MODULES = 5
)
(
  input  wire logic                     pclk,
  input  wire logic [NUM_MODULES-1:0]   key_osc_en,
  output logic      [NUM_MODULES*4-1:0] key_osc_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // key oscillators
  // ----------------------------------------------------------------
  // key k of a module toggles every k+1 clocks; a stopped oscillator
  // sits low so no stray edge reaches a counter that should hold
  logic [3:0] div [NUM_MODULES*4];

  always @(posedge pclk)
    for (int i = 0; i < NUM_MODULES * 4; i++)
      if (!key_osc_en[i / 4])
      begin
        div[i] <= 4'h0;
        key_osc_in[i] <= 1'b0;
      end
      else if (div[i] == 4'(i % 4))
      begin
        div[i] <= 4'h0;
        key_osc_in[i] <= !key_osc_in[i];
      end
      else
        div[i] <= div[i] + 4'h1;
endmodule

/* File: tb/touch_scan_chk.sv */
module touch_scan_chk
  import touch_pkg::*;
#(
  parameter int NUM_MODULES = 5
)
(
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire touch_pkg::apb_req_t       apb_req,
  input wire logic                      pready,
  input wire logic [touch_pkg::DATA_W-1:0] prdata,
  input wire logic                      pslverr,
  input wire logic [NUM_MODULES*4-1:0]  key_osc_in,
  input wire logic [NUM_MODULES*4-1:0]  key_pin_touch_sel,
  input wire logic [NUM_MODULES-1:0]    key_osc_en,
  input wire logic [NUM_MODULES-1:0]    ref_osc_en,
  input wire logic [NUM_MODULES*10-1:0] ref_osc_cap,
  input wire logic [1:0]                osc_freq_sel,
  input wire logic                      irq
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic        wr;
  logic        wr_ctl;
  logic        start_q;
  logic [3:0]  start_hist;
  logic [13:0] run_cnt;

  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign wr_ctl = wr && apb_req.paddr == OFS_CTL_MAIN;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      start_q <= 1'b0;
    else if (wr_ctl)
      start_q <= apb_req.pwdata[CTL_START];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      start_hist <= 4'h0;
    else
      start_hist <= {start_hist[2:0], wr_ctl & apb_req.pwdata[CTL_START]};

  // longest legal run is a zero preload: 256 units of 32 clocks
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      run_cnt <= 14'h0000;
    else
      run_cnt <= key_osc_en[0] ? run_cnt + 14'h0001 : 14'h0000;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ref_follow_a: assert property (ref_osc_en == key_osc_en)
    else $error("reference enables differ from key enables");
  start_on_a: assert property (wr_ctl && apb_req.pwdata[CTL_START] &&
    !start_q |-> ##[1:4] key_osc_en == {NUM_MODULES{1'b1}})
    else $error("start did not enable all oscillators");
  stop_idle_a: assert property (wr_ctl && !apb_req.pwdata[CTL_START]
    |-> ##[1:4] key_osc_en == '0)
    else $error("oscillators still on after stop");
  osc_cause_a: assert property ($rose(key_osc_en[0]) |-> start_hist != 0)
    else $error("oscillator started without a start write");
  run_bound_a: assert property (run_cnt <= 14'h2008)
    else $error("measurement window ran too long");
  irq_sticky_a: assert property ($fell(irq) |-> $past(wr &&
    (apb_req.paddr == OFS_IRQ_STAT || apb_req.paddr == OFS_IRQ_MASK)))
    else $error("irq dropped without software");
  ref_cap_a: assert property (wr && apb_req.paddr == OFS_MOD_BASE +
    {7'h00, MOFS_REF_LO} |=> ref_osc_cap[7:0] == $past(apb_req.pwdata[7:0]))
    else $error("reference capacitor not written");
  pin_sel_a: assert property (wr && apb_req.paddr == OFS_MOD_BASE +
    OFS_MOD_SPAN + {7'h00, MOFS_CTL_B} |=> key_pin_touch_sel[7:4] ==
    $past(apb_req.pwdata[3:0]))
    else $error("pin touch select not written");

  cover property (start_hist[0]);
  cover property ($rose(irq));
  cover property (apb_req.psel && apb_req.penable && pslverr);
endmodule

bind touch_key_scan_counters touch_scan_chk #(
  .NUM_MODULES(NUM_MODULES)
) u_chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .key_osc_in(key_osc_in),
  .key_pin_touch_sel(key_pin_touch_sel), .key_osc_en(key_osc_en),
  .ref_osc_en(ref_osc_en), .ref_osc_cap(ref_osc_cap),
  .osc_freq_sel(osc_freq_sel), .irq(irq)
);

/* File: tb/touch_key_scan_counters_bench.sv */
module touch_key_scan_counters_bench
  import touch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int NM = 5;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  apb_req_t         req = '0;
  logic             pready;
  logic             pslverr;
  logic             irq;
  logic             rd_err;
  logic [31:0]      prdata;
  logic [31:0]      rd_data;
  logic [31:0]      v;
  logic [NM*4-1:0]  key_osc_in;
  logic [NM*4-1:0]  key_pin_touch_sel;
  logic [NM-1:0]    key_osc_en;
  logic [NM-1:0]    ref_osc_en;
  logic [NM*10-1:0] ref_osc_cap;
  logic [1:0]       osc_freq_sel;
  logic [11:0]      ra [4] = '{OFS_PRELOAD, OFS_CTL_MAIN, OFS_OSC_FREQ,
                              OFS_IRQ_STAT};
  logic [31:0]      rv [4] = '{32'h0, 32'h0, 32'h3, 32'h0};
  int               bad_count = 0;
  int               num_checks = 0;
  int               cyc = 0;
  int               seed = 67583;

  touch_key_scan_counters #(.NUM_MODULES(NM)) u_dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .key_osc_in(key_osc_in),
    .key_pin_touch_sel(key_pin_touch_sel), .key_osc_en(key_osc_en),
    .ref_osc_en(ref_osc_en), .ref_osc_cap(ref_osc_cap),
    .osc_freq_sel(osc_freq_sel), .irq(irq));

  touch_pads #(.NUM_MODULES(NM)) u_pads (
    .pclk(pclk), .key_osc_en(key_osc_en), .key_osc_in(key_osc_in));

  always #2.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic near(input int a, input int b, input int t);
    return a >= b - t && a <= b + t;
  endfunction

  // one whole apb transfer; always entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_data = prdata;
    rd_err = pslverr;
    req <= '0;
    @(posedge pclk);
  endtask

  // low and high bytes are separate reads, so only use on a held count
  // kept four-state so an unknown count cannot pass as zero
  task automatic rd16(input logic [11:0] a, output logic [15:0] r);
    xfer(1'b0, a, 32'h0);
    r[7:0] = rd_data[7:0];
    xfer(1'b0, a + 12'h004, 32'h0);
    r[15:8] = rd_data[7:0];
  endtask

  task automatic run(input logic [7:0] pre, input logic [1:0] sel,
                     input logic share, input logic [1:0] key);
    int t0;
    int n;
    logic [15:0] fc;
    logic [15:0] mc;
    logic [15:0] r2;
    n = (256 - int'(pre)) * 32;
    xfer(1'b1, OFS_PRELOAD, {24'h0, pre});
    xfer(1'b1, OFS_MOD_BASE + 12'h010, {24'h0, key, 6'h00});
    xfer(1'b1, OFS_CTL_MAIN, {29'h0, share, sel});
    xfer(1'b1, OFS_CTL_MAIN, {26'h0, 1'b1, 2'b00, share, sel});
    @(negedge pclk);
    check(32'(key_osc_en), 32'({NM{1'b1}}));
    check(32'(ref_osc_en), 32'({NM{1'b1}}));
    t0 = cyc;
    while (irq !== 1'b1 && cyc - t0 < 9000)
      @(posedge pclk);
    check(32'(near(cyc - t0, n + 3, 4)), 32'h1);
    check(32'(key_osc_en), 32'h0);
    check(32'(ref_osc_en), 32'h0);
    xfer(1'b0, OFS_CTL_MAIN, 32'h0);
    check(32'(rd_data[6]), 32'h1);
    xfer(1'b0, OFS_IRQ_STAT, 32'h0);
    check(32'(rd_data[0]), 32'h1);
    rd16(OFS_FUNC_LO, fc);
    check(32'(near(fc, n >> sel, 2)), 32'h1);
    rd16(OFS_FUNC_LO, r2);
    check(32'(r2), 32'(fc));
    rd16(OFS_MOD_BASE, mc);
    check(32'(near(mc, n / (2 * (int'(key) + 1)), 3)), 32'h1);
    rd16(OFS_MOD_BASE, r2);
    check(32'(r2), 32'(mc));
    xfer(1'b1, OFS_IRQ_MASK, 32'h0);
    check(32'(irq), 32'h0);
    xfer(1'b1, OFS_IRQ_MASK, 32'h1);
    check(32'(irq), 32'h1);
    xfer(1'b1, OFS_IRQ_STAT, 32'h1);
    check(32'(irq), 32'h0);
    xfer(1'b1, OFS_CTL_MAIN, {26'h0, 1'b1, 2'b00, share, sel});
    repeat (4) @(posedge pclk);
    check(32'(key_osc_en), 32'h0);
    xfer(1'b1, OFS_CTL_MAIN, {29'h0, share, sel});
    rd16(OFS_FUNC_LO, fc);
    check(32'(fc), 32'h0);
    rd16(OFS_MOD_BASE, mc);
    check(32'(mc), 32'h0);
    $display("run done preload %0h clock select %0d", pre, sel);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, ra[i], 32'h0);
      check(rd_data, rv[i]);
    end
    check(32'(osc_freq_sel), 32'h3);
    xfer(1'b0, 12'h020, 32'h0);
    check(32'(rd_err), 32'h1);
    v = $random(seed);
    xfer(1'b1, OFS_PRELOAD, v);
    xfer(1'b0, OFS_PRELOAD, 32'h0);
    check(rd_data, {24'h0, v[7:0]});
    xfer(1'b1, OFS_MOD_BASE + {7'h00, MOFS_REF_LO}, v);
    check(32'(ref_osc_cap[7:0]), {24'h0, v[7:0]});
    xfer(1'b1, OFS_OSC_FREQ, v);
    check(32'(osc_freq_sel), {30'h0, v[1:0]});
    xfer(1'b1, OFS_MOD_BASE + OFS_MOD_SPAN + 12'h014, v);
    check(32'(key_pin_touch_sel[7:4]), {28'h0, v[3:0]});
    $display("register test done");
    xfer(1'b1, OFS_IRQ_MASK, 32'h1);
    run(8'hFF, 2'h0, 1'b0, 2'h0);
    for (int i = 0; i < 4; i++)
      run(8'hE0 | 8'($random(seed) & 31), 2'(i), 1'(i == 3), 2'(i));
    give_verdict();
  end
endmodule
